// file: shared/apt_defines.svh
`ifndef APT_DEFINES_SVH
`define APT_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define APT_OFF_WR1      8'h00
`define APT_OFF_WR2      8'h04
`define APT_OFF_WR3      8'h08
`define APT_OFF_LOGICAL  8'h0C
`define APT_OFF_REAL     8'h10
`define APT_OFF_UPPER    8'h14
`define APT_OFF_LOWER    8'h18
`define APT_OFF_RR1      8'h1C
`define APT_OFF_RR2      8'h20
`define APT_OFF_CMD      8'h24

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define APT_WR1_Z_LEVEL  4
`define APT_WR1_Z_EN     5
`define APT_WR1_Z_CLEAR  6
`define APT_WR2_SLIM_P   0
`define APT_WR2_SLIM_M   1
`define APT_WR2_CMP_SEL  5
`define APT_WR3_ENC_TYPE 0
`define APT_WR3_RING     6
`define APT_RR1_ABOVE    0
`define APT_RR1_BELOW    1
`define APT_RR2_SLIM_P   0
`define APT_RR2_SLIM_M   1
`define APT_CMD_PLUS     0
`define APT_CMD_MINUS    1
`define APT_CMD_DECEL    2
`define APT_CMD_STOP     3

// ---------------------------------------------------------------
// Reset values and responses
// ---------------------------------------------------------------
`define APT_CFG_RESET    8'h00
`define APT_WORD_RESET   32'h0000_0000
`define APT_RESP_OKAY    2'h0
`define APT_RESP_SLVERR  2'h2

`endif

// file: shared/apt_pkg.sv
package apt_pkg;

   typedef enum logic [1:0] {
      APT_IDLE,
      APT_RUN,
      APT_DECEL
   } apt_drive_t;

   typedef struct packed {
      apt_drive_t  drive;
      logic        dirMinus;
      logic        tick;
      logic        zPrev;
      logic        awHeld;
      logic [7:0]  awAddr;
      logic        wHeld;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [7:0]  wr1;
      logic [7:0]  wr2;
      logic [7:0]  wr3;
      logic [31:0] upper;
      logic [31:0] lower;
      logic        pulsePlus;
      logic        pulseMinus;
   } apt_state_t;

   typedef struct packed {
      logic [31:0] value;
   } apt_cnt_state_t;

   typedef struct packed {
      logic a;
      logic b;
   } apt_enc_state_t;

endpackage : apt_pkg

// file: hw/apt_pos_counter.sv
`timescale 1ns/1ps
`include "apt_defines.svh"

module apt_pos_counter (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        load,
   input  wire logic [31:0] loadValue,
   input  wire logic        clear,
   input  wire logic        countUp,
   input  wire logic        countDown,
   input  wire logic        ringEnable,
   input  wire logic [31:0] ringMax,
   output logic      [31:0] value
);

   apt_pkg::apt_cnt_state_t s;
   apt_pkg::apt_cnt_state_t next_s;

   // Host load wins over a clear, a clear wins over a count.
   always_comb begin
      next_s = s;
      if (load) begin
         next_s.value = loadValue;
      end else if (clear) begin
         next_s.value = `APT_WORD_RESET;
      end else if (countUp && !countDown) begin
         if (ringEnable && s.value == ringMax) begin
            next_s.value = `APT_WORD_RESET;
         end else begin
            next_s.value = s.value + 32'h0000_0001;
         end
      end else if (countDown && !countUp) begin
         if (ringEnable && s.value == `APT_WORD_RESET) begin
            next_s.value = ringMax;
         end else begin
            next_s.value = s.value - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign value = s.value;

endmodule : apt_pos_counter

// file: hw/apt_enc_decoder.sv
`timescale 1ns/1ps

module apt_enc_decoder (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic tick,
   input  wire logic upDownType,
   input  wire logic encA,
   input  wire logic encB,
   output logic      countUp,
   output logic      countDown
);

   apt_pkg::apt_enc_state_t s;
   apt_pkg::apt_enc_state_t next_s;
   logic                    step;

   // Inputs are sampled only on the divided tick, so an encoder edge must be
   // at least two clocks wide to be seen.
   always_comb begin
      next_s    = s;
      step      = (encA ^ s.a) ^ (encB ^ s.b);
      countUp   = 1'b0;
      countDown = 1'b0;
      if (tick) begin
         next_s.a = encA;
         next_s.b = encB;
         if (upDownType) begin
            countUp   = encA && !s.a;
            countDown = encB && !s.b;
         end else if (step) begin
            countUp   = (s.a == encB);
            countDown = (s.a != encB);
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule : apt_enc_decoder

// file: hw/apt_axis_position_tracking.sv
// Functional notes
// - Logical counter steps +1 per plus pulse, -1 per minus pulse.
// - Real counter follows encoder, quadrature or separate up/down pulses.
// - Both counters signed 32-bit, host reads or writes them anytime.
// - Two compare registers; select bit D5 picks logical or real counter.
// - First read register D0 set while selected counter above upper compare.
// - First read register D1 set while selected counter below lower compare.
// - Software limit active only with second write register D0 and D1 set.
// - Above upper while driving plus with limit active: decelerating stop, flag D0.
// - Upper limit flag clears itself once counter no longer above upper.
// - Host writes compare registers anytime and loads them before use.
// - Without ring, counters wrap all-ones to zero and back.
// - Third write register D6 enables ring; maxima from upper and lower.
// - With ring, max wraps to zero upward and zero to max downward.
// - One ring enable serves both counters of the axis.
// - Z clear mode: active Z stops pulses, clears real counter on rise.
// - Speed below initial speed: Z stops drive pulses immediately.
// - Only the Z stop input clears the real counter.
// - Z already active when clear config written still clears real counter.
`timescale 1ns/1ps
`include "apt_defines.svh"

module apt_axis_position_tracking (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic      [1:0]  bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        stepRequest,
   input  wire logic        constantSpeed,
   input  wire logic        decelDone,
   input  wire logic        zPhaseStopInput,
   input  wire logic        encA,
   input  wire logic        encB,
   output logic             drivePulsePlus,
   output logic             drivePulseMinus,
   output logic             driving,
   output logic             decelStopRequest
);

   // ---------------------------------------------------------------
   // State and shared combinational terms
   // ---------------------------------------------------------------
   apt_pkg::apt_state_t s;
   apt_pkg::apt_state_t next_s;

   logic [31:0] logicalValue;
   logic [31:0] realValue;
   logic [31:0] selected;
   logic        encUp;
   logic        encDown;
   logic        doWrite;
   logic [31:0] merged;
   logic        loadLogical;
   logic        loadReal;
   logic        issue;
   logic        zActive;
   logic        zHit;
   logic        clearReal;
   logic        aboveUpper;
   logic        belowLower;
   logic        softEnable;
   logic        softUpper;
   logic        softLower;
   logic        cmdWrite;
   logic [7:0]  newWr1;

   function automatic logic [31:0] apply_strobe(input logic [31:0] old, input logic [31:0] data,
                                                 input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = data[8*i +: 8];
         end
      end
      return r;
   endfunction : apply_strobe

   // ---------------------------------------------------------------
   // Counters and encoder input
   // ---------------------------------------------------------------
   apt_pos_counter logicalCounter (
      .clock      (clock),
      .srst       (srst),
      .load       (loadLogical),
      .loadValue  (merged),
      .clear      (1'b0),
      .countUp    (issue && !s.dirMinus),
      .countDown  (issue && s.dirMinus),
      .ringEnable (s.wr3[`APT_WR3_RING]),
      .ringMax    (s.upper),
      .value      (logicalValue)
   );

   apt_pos_counter realCounter (
      .clock      (clock),
      .srst       (srst),
      .load       (loadReal),
      .loadValue  (merged),
      .clear      (clearReal),
      .countUp    (encUp),
      .countDown  (encDown),
      .ringEnable (s.wr3[`APT_WR3_RING]),
      .ringMax    (s.lower),
      .value      (realValue)
   );

   apt_enc_decoder encoder (
      .clock      (clock),
      .srst       (srst),
      .tick       (s.tick),
      .upDownType (s.wr3[`APT_WR3_ENC_TYPE]),
      .encA       (encA),
      .encB       (encB),
      .countUp    (encUp),
      .countDown  (encDown)
   );

   // ---------------------------------------------------------------
   // Main logic
   // ---------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.tick = !s.tick;
      next_s.pulsePlus  = 1'b0;
      next_s.pulseMinus = 1'b0;

      doWrite  = s.awHeld && s.wHeld && !s.bvalid;
      merged   = `APT_WORD_RESET;
      newWr1   = s.wr1;
      cmdWrite = 1'b0;
      loadLogical = 1'b0;
      loadReal    = 1'b0;

      // Counters are live; a read returns their value at the read edge.
      selected   = s.wr2[`APT_WR2_CMP_SEL] ? realValue : logicalValue;
      aboveUpper = $signed(selected) > $signed(s.upper);
      belowLower = $signed(selected) < $signed(s.lower);
      softEnable = s.wr2[`APT_WR2_SLIM_P] && s.wr2[`APT_WR2_SLIM_M];
      softUpper  = softEnable && aboveUpper;
      softLower  = softEnable && belowLower;

      zActive = (zPhaseStopInput == s.wr1[`APT_WR1_Z_LEVEL]);
      zHit    = s.wr1[`APT_WR1_Z_EN] && zActive;
      // Taken only after zActive is settled, so the edge detector never sees a stale level.
      next_s.zPrev = zActive;

      // ----- Write channel -----
      if (awvalid && awready) begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = awaddr;
      end
      if (wvalid && wready) begin
         next_s.wHeld = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
      end
      if (doWrite) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = `APT_RESP_OKAY;
         unique case (s.awAddr)
            `APT_OFF_WR1: begin
               merged     = apply_strobe({24'h00_0000, s.wr1}, s.wData, s.wStrb);
               newWr1     = merged[7:0];
               next_s.wr1 = newWr1;
            end
            `APT_OFF_WR2: begin
               merged     = apply_strobe({24'h00_0000, s.wr2}, s.wData, s.wStrb);
               next_s.wr2 = merged[7:0];
            end
            `APT_OFF_WR3: begin
               merged     = apply_strobe({24'h00_0000, s.wr3}, s.wData, s.wStrb);
               next_s.wr3 = merged[7:0];
            end
            `APT_OFF_LOGICAL: begin
               merged      = apply_strobe(logicalValue, s.wData, s.wStrb);
               loadLogical = 1'b1;
            end
            `APT_OFF_REAL: begin
               merged   = apply_strobe(realValue, s.wData, s.wStrb);
               loadReal = 1'b1;
            end
            `APT_OFF_UPPER: begin
               merged       = apply_strobe(s.upper, s.wData, s.wStrb);
               next_s.upper = merged;
            end
            `APT_OFF_LOWER: begin
               merged       = apply_strobe(s.lower, s.wData, s.wStrb);
               next_s.lower = merged;
            end
            `APT_OFF_RR1, `APT_OFF_RR2: begin
               merged = `APT_WORD_RESET;
            end
            `APT_OFF_CMD: begin
               merged   = apply_strobe(`APT_WORD_RESET, s.wData, s.wStrb);
               cmdWrite = 1'b1;
            end
            default: begin
               next_s.bresp = `APT_RESP_SLVERR;
            end
         endcase
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end

      // Rising edge of the active level, or a config write that finds the
      // input already active; nothing else reaches the real counter clear.
      clearReal = s.wr1[`APT_WR1_Z_EN] && s.wr1[`APT_WR1_Z_CLEAR]
                  && zActive && !s.zPrev;
      if (doWrite && s.awAddr == `APT_OFF_WR1 && newWr1[`APT_WR1_Z_EN] && newWr1[`APT_WR1_Z_CLEAR]
          && (zPhaseStopInput == newWr1[`APT_WR1_Z_LEVEL])) begin
         clearReal = 1'b1;
      end

      // ----- Read channel -----
      if (arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = `APT_RESP_OKAY;
         unique case (araddr)
            `APT_OFF_WR1:     next_s.rdata = {24'h00_0000, s.wr1};
            `APT_OFF_WR2:     next_s.rdata = {24'h00_0000, s.wr2};
            `APT_OFF_WR3:     next_s.rdata = {24'h00_0000, s.wr3};
            `APT_OFF_LOGICAL: next_s.rdata = logicalValue;
            `APT_OFF_REAL:    next_s.rdata = realValue;
            `APT_OFF_UPPER:   next_s.rdata = s.upper;
            `APT_OFF_LOWER:   next_s.rdata = s.lower;
            `APT_OFF_RR1:     next_s.rdata = {30'h0000_0000, belowLower, aboveUpper};
            `APT_OFF_RR2:     next_s.rdata = {30'h0000_0000, softLower, softUpper};
            `APT_OFF_CMD:     next_s.rdata = {30'h0000_0000, s.drive == apt_pkg::APT_DECEL,
                                              s.drive != apt_pkg::APT_IDLE};
            default: begin
               next_s.rdata = `APT_WORD_RESET;
               next_s.rresp = `APT_RESP_SLVERR;
            end
         endcase
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // ----- Drive sequencing -----
      issue = 1'b0;
      unique case (s.drive)
         apt_pkg::APT_IDLE: begin
            if (cmdWrite && merged[`APT_CMD_PLUS]) begin
               next_s.drive    = apt_pkg::APT_RUN;
               next_s.dirMinus = 1'b0;
            end else if (cmdWrite && merged[`APT_CMD_MINUS]) begin
               next_s.drive    = apt_pkg::APT_RUN;
               next_s.dirMinus = 1'b1;
            end
         end
         apt_pkg::APT_RUN, apt_pkg::APT_DECEL: begin
            if ((cmdWrite && merged[`APT_CMD_STOP]) || (zHit && constantSpeed)) begin
               next_s.drive = apt_pkg::APT_IDLE;
            end else begin
               issue = s.tick && stepRequest;
               if (s.drive == apt_pkg::APT_DECEL && decelDone) begin
                  next_s.drive = apt_pkg::APT_IDLE;
               end else if (zHit || (cmdWrite && merged[`APT_CMD_DECEL])
                            || (softUpper && !s.dirMinus)
                            || (softLower && s.dirMinus)) begin
                  next_s.drive = apt_pkg::APT_DECEL;
               end
            end
         end
      endcase
      next_s.pulsePlus  = issue && !s.dirMinus;
      next_s.pulseMinus = issue && s.dirMinus;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s      <= '0;
         s.wr1  <= `APT_CFG_RESET;
         s.wr2  <= `APT_CFG_RESET;
         s.wr3  <= `APT_CFG_RESET;
         s.drive <= apt_pkg::APT_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign awready          = !s.awHeld && !s.bvalid;
   assign wready           = !s.wHeld && !s.bvalid;
   assign bvalid           = s.bvalid;
   assign bresp            = s.bresp;
   assign arready          = !s.rvalid;
   assign rvalid           = s.rvalid;
   assign rdata            = s.rdata;
   assign rresp            = s.rresp;
   assign drivePulsePlus   = s.pulsePlus;
   assign drivePulseMinus  = s.pulseMinus;
   assign driving          = (s.drive != apt_pkg::APT_IDLE);
   assign decelStopRequest = (s.drive == apt_pkg::APT_DECEL);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence plus_step_s;
      issue && !s.dirMinus && !loadLogical && !s.wr3[`APT_WR3_RING];
   endsequence
   sequence write_taken_s;
      doWrite;
   endsequence

   logical_up_a: assert property (plus_step_s |=> logicalValue == $past(logicalValue) + 32'h0000_0001)
      else $error("logical counter missed an up count");
   logical_down_a: assert property (issue && s.dirMinus && !loadLogical && !s.wr3[`APT_WR3_RING]
      |=> logicalValue == $past(logicalValue) - 32'h0000_0001)
      else $error("logical counter missed a down count");
   pulse_count_a: assert property (issue |=> (drivePulsePlus || drivePulseMinus))
      else $error("issued step produced no pulse");
   ring_wrap_a: assert property (s.wr3[`APT_WR3_RING] && logicalValue == s.upper && issue && !s.dirMinus
      && !loadLogical |=> logicalValue == 32'h0000_0000)
      else $error("ring did not wrap to zero");
   rr1_read_a: assert property (arvalid && arready && araddr == `APT_OFF_RR1
      |=> rvalid && rdata[1:0] == $past({belowLower, aboveUpper}))
      else $error("compare flags read wrong");
   soft_stop_a: assert property (s.drive == apt_pkg::APT_RUN && softUpper && !s.dirMinus && !zHit
      && !cmdWrite |=> s.drive == apt_pkg::APT_DECEL)
      else $error("upper soft limit did not decelerate");
   z_clear_a: assert property (clearReal && !loadReal |=> realValue == 32'h0000_0000)
      else $error("real counter not cleared by Z phase");
   z_stop_a: assert property (s.drive != apt_pkg::APT_IDLE && zHit && constantSpeed
      |=> !driving ##1 !drivePulsePlus && !drivePulseMinus)
      else $error("Z phase did not stop pulses at once");
   write_resp_a: assert property (write_taken_s |=> bvalid)
      else $error("write gave no response");

endmodule : apt_axis_position_tracking

// file: bench/apt_enc_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Encoder feedback, up/down pulse form
// ----------------------------------------------------------------
module apt_enc_model (
   input  wire logic clock,
   input  wire logic goUp,
   input  wire logic goDown,
   output logic      encA,
   output logic      encB
);
   logic [2:0] ageA = 3'h0;
   logic [2:0] ageB = 3'h0;
   // Pulses last four clocks because the decoder samples only every other clock.
   always_ff @(posedge clock) begin
      ageA <= goUp ? 3'h4 : ageA - {2'h0, ageA != 3'h0};
      ageB <= goDown ? 3'h4 : ageB - {2'h0, ageB != 3'h0};
   end
   assign encA = ageA != 3'h0;
   assign encB = ageB != 3'h0;
endmodule : apt_enc_model

// file: bench/tb_axis_position_tracking.sv
`timescale 1ns/1ps
`include "apt_defines.svh"
module tb_axis_position_tracking;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} apt_row_t;
   logic clock, srst, awvalid, wvalid, bready, arvalid, rready, stepRequest, constantSpeed, decelDone, zIn, goUp, goDown;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs, bs;
   logic awready, wready, bvalid, arready, rvalid, encA, encB, pPlus, pMinus, driving, decel;
   int mismatches, samples_checked, cycles, plusSeen, minusSeen;
   apt_row_t rows[8];
   apt_axis_position_tracking i_dut (.clock(clock), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .stepRequest(stepRequest), .constantSpeed(constantSpeed),
      .decelDone(decelDone), .zPhaseStopInput(zIn), .encA(encA), .encB(encB), .drivePulsePlus(pPlus),
      .drivePulseMinus(pMinus), .driving(driving), .decelStopRequest(decel));
   apt_enc_model i_enc (.clock(clock), .goUp(goUp), .goDown(goDown), .encA(encA), .encB(encB));
   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (!((awvalid === 1'b0 || awready === 1'b1) && (wvalid === 1'b0 || wready === 1'b1)));
      do @(posedge clock); while (bvalid !== 1'b1);
      bs = bresp;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
      rd = rdata; rs = rresp;
   endtask : axr
   task automatic step();
      @(posedge clock) stepRequest <= 1'b1;
      repeat (2) @(posedge clock);
      stepRequest <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : step
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (pPlus === 1'b1) plusSeen++;
      if (pMinus === 1'b1) minusSeen++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      {srst, awvalid, wvalid, bready, arvalid, rready, stepRequest, constantSpeed, decelDone, zIn} = 10'h200;
      {goUp, goDown, awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      rows = '{'{`APT_OFF_WR1, 32'hFFFF_FF0F, 32'h0000_000F, 2'h0}, '{`APT_OFF_WR2, 32'h0000_0020, 32'h0000_0020, 2'h0},
         '{`APT_OFF_WR3, 32'h0000_0001, 32'h0000_0001, 2'h0}, '{`APT_OFF_UPPER, 32'h1234_5678, 32'h1234_5678, 2'h0},
         '{`APT_OFF_LOWER, 32'h8000_0000, 32'h8000_0000, 2'h0}, '{`APT_OFF_LOGICAL, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 2'h0},
         '{`APT_OFF_REAL, 32'hDEAD_BEEF, 32'hDEAD_BEEF, 2'h0}, '{8'h3C, 32'h0000_0001, 32'h0, `APT_RESP_SLVERR}};
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      axr(`APT_OFF_CMD); chk(rd, 32'h0);
      foreach (rows[i]) begin
         axw(rows[i].a, rows[i].d); chk(bs, rows[i].r);
         axr(rows[i].a); chk(rs, rows[i].r);
         if (rows[i].r == 2'h0) chk(rd, rows[i].e);
      end
      // Wrap of the logical counter without ring, then compare flags on it.
      axw(`APT_OFF_WR2, 32'h0); axw(`APT_OFF_WR3, 32'h0); axw(`APT_OFF_LOGICAL, 32'hFFFF_FFFF);
      axw(`APT_OFF_CMD, 32'h1); step(); axr(`APT_OFF_LOGICAL); chk(rd, 32'h0);
      chk(plusSeen, 32'h1);
      axw(`APT_OFF_CMD, 32'h8); axw(`APT_OFF_CMD, 32'h2); step(); axr(`APT_OFF_LOGICAL); chk(rd, 32'hFFFF_FFFF);
      chk(minusSeen, 32'h1);
      axw(`APT_OFF_CMD, 32'h8);
      axw(`APT_OFF_UPPER, 32'h5); axw(`APT_OFF_LOWER, 32'hFFFF_FFFB);
      axw(`APT_OFF_LOGICAL, 32'h6); axr(`APT_OFF_RR1); chk(rd, 32'h1);
      axw(`APT_OFF_LOGICAL, 32'hFFFF_FFFA); axr(`APT_OFF_RR1); chk(rd, 32'h2);
      axw(`APT_OFF_REAL, 32'h0); axw(`APT_OFF_WR2, 32'h20); axr(`APT_OFF_RR1); chk(rd, 32'h0);
      // Soft limit in both directions, ending each decelerating stop.
      axw(`APT_OFF_WR2, 32'h3);
      for (int k = 0; k < 2; k++) begin
         axw(`APT_OFF_LOGICAL, k ? 32'hFFFF_FFFB : 32'h5); axw(`APT_OFF_CMD, k ? 32'h2 : 32'h1);
         step(); chk(decel, 1'b1);
         axr(`APT_OFF_RR2); chk(rd, k ? 32'h2 : 32'h1);
         @(posedge clock) decelDone <= 1'b1;
         @(posedge clock) decelDone <= 1'b0;
         @(posedge clock); chk(driving, 1'b0);
      end
      axw(`APT_OFF_LOGICAL, 32'h0); axr(`APT_OFF_RR2); chk(rd, 32'h0);
      // Variable ring on both counters.
      axw(`APT_OFF_WR2, 32'h0); axw(`APT_OFF_WR3, 32'h41); axw(`APT_OFF_UPPER, 32'h9); axw(`APT_OFF_LOWER, 32'h4);
      axw(`APT_OFF_LOGICAL, 32'h9); axw(`APT_OFF_CMD, 32'h1); step(); axr(`APT_OFF_LOGICAL); chk(rd, 32'h0);
      axw(`APT_OFF_CMD, 32'h8); axw(`APT_OFF_CMD, 32'h2); step(); axr(`APT_OFF_LOGICAL); chk(rd, 32'h9);
      axw(`APT_OFF_CMD, 32'h8); axw(`APT_OFF_REAL, 32'h4);
      @(posedge clock) goUp <= 1'b1;
      @(posedge clock) goUp <= 1'b0;
      repeat (8) @(posedge clock);
      axr(`APT_OFF_REAL); chk(rd, 32'h0);
      @(posedge clock) goDown <= 1'b1;
      @(posedge clock) goDown <= 1'b0;
      repeat (8) @(posedge clock);
      axr(`APT_OFF_REAL); chk(rd, 32'h4);
      // Quadrature: A leads B by two clocks, four forward steps in all.
      axw(`APT_OFF_WR3, 32'h0); axw(`APT_OFF_REAL, 32'h0);
      @(posedge clock) goUp <= 1'b1;
      @(posedge clock) goUp <= 1'b0;
      @(posedge clock) goDown <= 1'b1;
      @(posedge clock) goDown <= 1'b0;
      repeat (8) @(posedge clock);
      axr(`APT_OFF_REAL); chk(rd, 32'h4);
      // Z stop with clear, then clear with the input already active.
      axw(`APT_OFF_WR3, 32'h0); axw(`APT_OFF_WR1, 32'h70); axw(`APT_OFF_REAL, 32'h7);
      constantSpeed <= 1'b1;
      axw(`APT_OFF_CMD, 32'h1); chk(driving, 1'b1);
      @(posedge clock) zIn <= 1'b1;
      repeat (3) @(posedge clock);
      chk(driving, 1'b0);
      axr(`APT_OFF_REAL); chk(rd, 32'h0);
      // The input is already active under the old level, so only the write itself can clear.
      axw(`APT_OFF_WR1, 32'h10); axw(`APT_OFF_REAL, 32'h9); axw(`APT_OFF_WR1, 32'h70);
      axr(`APT_OFF_REAL); chk(rd, 32'h0);
      // Mid-run reset drops the Z clear configuration.
      @(posedge clock) srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      axr(`APT_OFF_WR1); chk(rd, 32'h0);
      finish_test();
   end
endmodule : tb_axis_position_tracking
